// [sdct_bank.sv]
// One bank's activation age and auto precharge hold-off.
// Assumes tick_i is a one-cycle pulse per memory clock rising edge.
module sdct_bank (
    input  wire logic                      sys_clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      tick_i,
    input  wire logic                      activate_i,
    input  wire logic                      close_i,
    input  wire logic                      ap_arm_i,
    input  wire logic [sdct_pkg::CNT_W-1:0] ap_wait_i,
    input  wire logic [sdct_pkg::CNT_W-1:0] ras_min_i,
    output logic                           precharge_o,
    output logic                           open_o
);

    typedef struct packed {
        logic [sdct_pkg::CNT_W-1:0] age;
        logic [sdct_pkg::CNT_W-1:0] wait_cnt;
        logic                       pending;
        logic                       open;
        logic                       fire;
    } sdct_bank_s;

    sdct_bank_s                 st_r;
    sdct_bank_s                 st_nxt;
    logic                       ready;
    logic [sdct_pkg::CNT_W-1:0] age_step;

    // Age and wait as they stand once this edge is counted
    assign age_step = (st_r.age != '1) ? st_r.age + 1'b1 : st_r.age;
    assign ready    = st_r.pending && (age_step >= ras_min_i) &&
                      (st_r.wait_cnt <= 8'h01);

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.fire = 1'b0;
        if (tick_i)
        begin
            // Age in whole memory clock edges
            if (st_r.age != '1)
                st_nxt.age = st_r.age + 1'b1;
            if (st_r.wait_cnt != '0)
                st_nxt.wait_cnt = st_r.wait_cnt - 1'b1;
            if (ready)
            begin
                // Internal precharge held until bank old enough
                st_nxt.fire    = 1'b1;
                st_nxt.pending = 1'b0;
                st_nxt.open    = 1'b0;
            end
            if (activate_i)
            begin
                // Reopened bank takes no internal precharge
                st_nxt.fire    = 1'b0;
                st_nxt.age     = '0;
                st_nxt.open    = 1'b1;
                st_nxt.pending = 1'b0;
            end
            else if (close_i)
            begin
                st_nxt.open    = 1'b0;
                st_nxt.pending = 1'b0;
            end
            else if (ap_arm_i)
            begin
                st_nxt.pending  = 1'b1;
                st_nxt.wait_cnt = ap_wait_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign precharge_o = st_r.fire;
    assign open_o      = st_r.open;

    a_ap_ras_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        precharge_o |-> st_r.age >= ras_min_i)
        else $error("internal precharge before activate to precharge minimum");

    a_ap_fires: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (tick_i && ready && !activate_i) |=> precharge_o)
        else $error("internal precharge missing when due");

    a_age_edges: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (tick_i && activate_i) |=> (st_r.age == '0) ##0 open_o)
        else $error("activation age not restarted");

endmodule : sdct_bank

// [sdct_ctrl_model.sv]
// Controller-side model: free-running memory clock and command pins.
// Assumes one bench process at a time calls send_cmd.
module sdct_ctrl_model (
    output logic                     ck_o,
    output sdct_pkg::sdct_cmd_pins_s pins_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] act_age;

    initial
    begin
        ck_o    = 1'b0;
        // Only activate, read, write and precharge; all pins start high, deselected
        pins_o  = '1;
        act_age = '0;
        #7;
        forever #100 ck_o = ~ck_o;
    end

    // Clocks since the last activation
    always @(posedge ck_o)
        act_age <= (pins_o[7:4] == 4'h3) ? 16'h0000 : act_age + 16'h0001;

    // Command set on a falling edge, held one whole clock
    task automatic send_cmd(input logic [3:0] code, input logic [2:0] bank, input logic ap);
        @(negedge ck_o);
        pins_o <= {code, bank, ap};
        @(negedge ck_o);
        pins_o <= {1'b1, ~pins_o[6:0]};
    endtask : send_cmd
endmodule : sdct_ctrl_model

// [sdct_pkg.sv]
// Shared types and constants for the command timing block.
// Assumes one system clock that oversamples the memory clock pin.
package sdct_pkg;

    localparam int unsigned SYNC_STAGES       = 2;
    localparam int unsigned NUM_BANKS         = 8;
    localparam int unsigned BANK_W            = 3;
    localparam int unsigned LAT_W             = 5;
    localparam int unsigned CNT_W             = 8;
    localparam int unsigned PIPE_W            = 64;
    localparam int unsigned IDX_W             = 6;

    // Write recovery floor while the delay loop is off
    localparam int unsigned WR_DLL_OFF_NS     = 15;
    localparam logic [CNT_W-1:0] WR_DLL_OFF_MIN_CK = 8'h04;

    // Edge count from write latency point to recovery start
    localparam logic [IDX_W-1:0] WR_START_FULL = 6'h04;
    localparam logic [IDX_W-1:0] WR_START_CHOP = 6'h02;

    // Plain default for activate to precharge minimum, in memory clocks
    localparam logic [CNT_W-1:0] ACT_TO_PRE_MIN_DEF = 8'h0f;
    localparam int unsigned CK_PERIOD_PS_DEF  = 200000;

    typedef enum logic [1:0] {
        SDCT_BURST_FIXED_EIGHT,
        SDCT_BURST_FIXED_CHOP,
        SDCT_BURST_PER_COMMAND
    } sdct_burst_e;

    typedef enum logic [2:0] {
        SDCT_CMD_NONE,
        SDCT_CMD_ACTIVATE,
        SDCT_CMD_READ,
        SDCT_CMD_WRITE,
        SDCT_CMD_PRECHARGE
    } sdct_cmd_e;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] bank;
        logic              auto_pre;
    } sdct_cmd_pins_s;

    typedef struct packed {
        logic [LAT_W-1:0]  read_latency;
        logic [LAT_W-1:0]  additive_latency;
        logic [LAT_W-1:0]  write_latency;
        sdct_burst_e       burst_mode;
        logic              delay_loop_disabled;
        logic [CNT_W-1:0]  write_recovery_interval;
        logic [CNT_W-1:0]  activate_to_precharge_min;
    } sdct_mode_cfg_s;

endpackage : sdct_pkg

// [sdct_top.sv]
// Command timing core: samples the memory clock and command pins, tracks banks,
// write recovery start and the read strobe reference edge.
// Assumes sys_clk_i is several times faster than the memory clock on ck_i.
//
// Function
// - Spacings count whole memory clock edges, rounded up from nanoseconds.
// - Auto precharge internal precharge waits until activate to precharge minimum.
// - Delay loop off: write recovery is max of four clocks and 15 ns.
// - Recovery starts four edges after write latency, two for fixed chop.
// - Delay loop off: strobe reference at read latency plus additive minus one.
module sdct_top #(
    parameter int unsigned CK_PERIOD_PS = sdct_pkg::CK_PERIOD_PS_DEF
) (
    input  wire logic                            sys_clk_i,
    input  wire logic                            resetn_i,
    input  wire logic                            ck_i,
    input  wire sdct_pkg::sdct_cmd_pins_s        cmd_pins_i,
    input  wire sdct_pkg::sdct_mode_cfg_s        mode_cfg_i,
    output logic [sdct_pkg::NUM_BANKS-1:0]       int_precharge_o,
    output logic [sdct_pkg::NUM_BANKS-1:0]       bank_open_o,
    output logic                                 recovery_start_o,
    output logic                                 read_strobe_ref_o,
    output logic [sdct_pkg::CNT_W-1:0]           write_recovery_ck_o
);

    localparam int unsigned WR_DLL_OFF_RU =
        (sdct_pkg::WR_DLL_OFF_NS * 1000 + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
    localparam logic [sdct_pkg::CNT_W-1:0] WR_DLL_OFF_CK =
        sdct_pkg::CNT_W'(WR_DLL_OFF_RU);

    typedef struct packed {
        logic [sdct_pkg::SYNC_STAGES-1:0] ck_sync;
        logic                             ck_last;
        sdct_pkg::sdct_cmd_pins_s         pins_s1;
        sdct_pkg::sdct_cmd_pins_s         pins_s2;
        logic [sdct_pkg::PIPE_W-1:0]      rd_pipe;
        logic [sdct_pkg::PIPE_W-1:0]      wr_pipe;
        logic                             rd_ref;
        logic                             wr_start;
        logic [sdct_pkg::CNT_W-1:0]       wr_ck;
    } sdct_top_s;

    sdct_top_s                   st_r;
    sdct_top_s                   st_nxt;
    logic                        tick;
    sdct_pkg::sdct_cmd_e         cmd;
    logic [sdct_pkg::CNT_W-1:0]  wr_sel;
    logic [sdct_pkg::IDX_W-1:0]  rd_idx;
    logic [sdct_pkg::IDX_W-1:0]  wr_idx;
    logic [sdct_pkg::IDX_W-1:0]  wr_off;
    logic [sdct_pkg::CNT_W-1:0]  ap_wait;

    function automatic sdct_pkg::sdct_cmd_e decode_cmd(input sdct_pkg::sdct_cmd_pins_s p);
        logic [3:0] c;
        c = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
        case (c)
            4'h3:    decode_cmd = sdct_pkg::SDCT_CMD_ACTIVATE;
            4'h5:    decode_cmd = sdct_pkg::SDCT_CMD_READ;
            4'h4:    decode_cmd = sdct_pkg::SDCT_CMD_WRITE;
            4'h2:    decode_cmd = sdct_pkg::SDCT_CMD_PRECHARGE;
            default: decode_cmd = sdct_pkg::SDCT_CMD_NONE;
        endcase
    endfunction : decode_cmd

    // Rising memory clock edge from the second stage onward only
    assign tick = st_r.ck_sync[1] && !st_r.ck_last;
    assign cmd  = decode_cmd(st_r.pins_s2);

    // Write recovery length, fixed at the floor when the delay loop is off
    always_comb
    begin
        wr_sel = mode_cfg_i.write_recovery_interval;
        if (mode_cfg_i.delay_loop_disabled)
        begin
            wr_sel = (WR_DLL_OFF_CK > sdct_pkg::WR_DLL_OFF_MIN_CK) ?
                     WR_DLL_OFF_CK : sdct_pkg::WR_DLL_OFF_MIN_CK;
        end
    end

    assign wr_off  = (mode_cfg_i.burst_mode == sdct_pkg::SDCT_BURST_FIXED_CHOP) ?
                     sdct_pkg::WR_START_CHOP : sdct_pkg::WR_START_FULL;
    assign wr_idx  = sdct_pkg::IDX_W'(mode_cfg_i.write_latency) + wr_off - 1'b1;
    // Reference edge at read plus additive latency less one, so pipe slot less two
    assign rd_idx  = (sdct_pkg::IDX_W'(mode_cfg_i.read_latency)
                     + sdct_pkg::IDX_W'(mode_cfg_i.additive_latency) > 6'h02) ?
                     sdct_pkg::IDX_W'(mode_cfg_i.read_latency)
                     + sdct_pkg::IDX_W'(mode_cfg_i.additive_latency) - 6'h02 :
                     6'h00;
    assign ap_wait = sdct_pkg::CNT_W'(wr_idx) + 8'h01 + wr_sel;

    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.ck_sync  = {st_r.ck_sync[0], ck_i};
        st_nxt.ck_last  = st_r.ck_sync[1];
        st_nxt.pins_s1  = cmd_pins_i;
        st_nxt.pins_s2  = st_r.pins_s1;
        st_nxt.rd_ref   = 1'b0;
        st_nxt.wr_start = 1'b0;
        st_nxt.wr_ck    = wr_sel;
        if (tick)
        begin
            st_nxt.rd_ref   = st_r.rd_pipe[0];
            st_nxt.wr_start = st_r.wr_pipe[0];
            st_nxt.rd_pipe  = st_r.rd_pipe >> 1;
            st_nxt.wr_pipe  = st_r.wr_pipe >> 1;
            if (cmd == sdct_pkg::SDCT_CMD_READ)
                st_nxt.rd_pipe[rd_idx] = 1'b1;
            if (cmd == sdct_pkg::SDCT_CMD_WRITE)
                st_nxt.wr_pipe[wr_idx] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    genvar b;
    generate
        for (b = 0; b < sdct_pkg::NUM_BANKS; b++)
        begin : g_bank
            logic hit;
            assign hit = (st_r.pins_s2.bank == sdct_pkg::BANK_W'(b));
            sdct_bank u_bank (
                .sys_clk_i   (sys_clk_i),
                .resetn_i    (resetn_i),
                .tick_i      (tick),
                .activate_i  (hit && cmd == sdct_pkg::SDCT_CMD_ACTIVATE),
                .close_i     (hit && cmd == sdct_pkg::SDCT_CMD_PRECHARGE),
                .ap_arm_i    (hit && st_r.pins_s2.auto_pre &&
                              (cmd == sdct_pkg::SDCT_CMD_READ ||
                               cmd == sdct_pkg::SDCT_CMD_WRITE)),
                .ap_wait_i   ((cmd == sdct_pkg::SDCT_CMD_WRITE) ? ap_wait : '0),
                .ras_min_i   (mode_cfg_i.activate_to_precharge_min),
                .precharge_o (int_precharge_o[b]),
                .open_o      (bank_open_o[b])
            );
        end
    endgenerate

    assign recovery_start_o    = st_r.wr_start;
    assign read_strobe_ref_o   = st_r.rd_ref;
    assign write_recovery_ck_o = st_r.wr_ck;

    sequence s_write_taken;
        tick && cmd == sdct_pkg::SDCT_CMD_WRITE;
    endsequence

    sequence s_read_taken;
        tick && cmd == sdct_pkg::SDCT_CMD_READ;
    endsequence

    sequence s_write_due;
        tick && st_r.wr_pipe[0];
    endsequence

    // Memory clock edge detection
    a_tick_single: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        tick |=> !tick ##1 !tick)
        else $error("memory clock edge seen twice");

    a_wr_dll_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        mode_cfg_i.delay_loop_disabled |-> wr_sel >= 8'h04 && wr_sel >= WR_DLL_OFF_CK)
        else $error("write recovery below floor with delay loop off");

    a_wr_dll_on: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !mode_cfg_i.delay_loop_disabled |->
        wr_sel == mode_cfg_i.write_recovery_interval)
        else $error("write recovery not taken from setting");

    a_wr_ck_held: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        write_recovery_ck_o == $past(wr_sel))
        else $error("write recovery output not registered");

    a_wr_start_slot: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_taken |=> st_r.wr_pipe[$past(wr_idx)])
        else $error("write recovery start not scheduled");

    a_wr_chop_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        mode_cfg_i.burst_mode == sdct_pkg::SDCT_BURST_FIXED_CHOP |->
        wr_idx == sdct_pkg::IDX_W'(mode_cfg_i.write_latency) + 6'h01)
        else $error("fixed chop recovery start offset wrong");

    a_wr_full_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        mode_cfg_i.burst_mode != sdct_pkg::SDCT_BURST_FIXED_CHOP |->
        wr_idx == sdct_pkg::IDX_W'(mode_cfg_i.write_latency) + 6'h03)
        else $error("eight beat recovery start offset wrong");

    a_wr_start_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_due |=> recovery_start_o ##1 !recovery_start_o)
        else $error("write recovery start pulse malformed");

    a_wr_start_edge: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        recovery_start_o |-> $past(tick))
        else $error("write recovery start away from a memory clock edge");

    a_rd_ref_slot: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        s_read_taken |=> st_r.rd_pipe[$past(rd_idx)])
        else $error("read strobe reference not scheduled");

    a_rd_ref_clamp: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        s_read_taken ##0 (sdct_pkg::IDX_W'(mode_cfg_i.read_latency) +
        sdct_pkg::IDX_W'(mode_cfg_i.additive_latency) <= 6'h02) |=> st_r.rd_pipe[0])
        else $error("short read latency reference not on next edge");

    a_rd_ref_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (tick && st_r.rd_pipe[0]) |=> read_strobe_ref_o ##1 !read_strobe_ref_o)
        else $error("read strobe reference pulse malformed");

    a_rd_ref_edge: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        read_strobe_ref_o |-> $past(tick))
        else $error("strobe reference away from a memory clock edge");

endmodule : sdct_top

// [sdct_top_tb.sv]
// Self-checking bench for the command timing core.
// Assumes the controller model supplies the memory clock and command pins.
module sdct_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned CK_PS   = 2000;
    localparam int unsigned TIMEOUT = 20000;
    // Memory clocks in eight postponed refresh intervals; no refresh is sent
    localparam logic [15:0] REF_POSTPONE_CK = 16'h0138;

    logic                     sys_clk;
    logic                     resetn;
    logic                     ck;
    sdct_pkg::sdct_cmd_pins_s pins;
    sdct_pkg::sdct_mode_cfg_s cfg;
    logic [7:0]               int_pre;
    logic [7:0]               bank_open;
    logic                     rec_start;
    logic                     strobe_ref;
    logic [7:0]               wr_ck;
    logic [15:0]              ck_cnt;
    int                       cyc;
    int                       fails;
    int                       samples_checked;

    sdct_ctrl_model model_u (.ck_o(ck), .pins_o(pins));

    sdct_top #(.CK_PERIOD_PS(CK_PS)) dut_u (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .ck_i(ck), .cmd_pins_i(pins),
        .mode_cfg_i(cfg), .int_precharge_o(int_pre), .bank_open_o(bank_open),
        .recovery_start_o(rec_start), .read_strobe_ref_o(strobe_ref),
        .write_recovery_ck_o(wr_ck)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge ck)
        ck_cnt <= ck_cnt + 16'h0001;

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == TIMEOUT)
        begin
            fails++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk

    task automatic set_cfg(input logic [4:0] rl, input logic [4:0] al, input logic [4:0] wl,
                           input logic [1:0] bm, input logic dll, input logic [7:0] wr);
        @(posedge sys_clk);
        #2;
        cfg.read_latency              = rl;
        cfg.additive_latency          = al;
        cfg.write_latency             = wl;
        cfg.burst_mode                = sdct_pkg::sdct_burst_e'(bm);
        cfg.delay_loop_disabled       = dll;
        cfg.write_recovery_interval   = wr;
        cfg.activate_to_precharge_min = 8'h0a;
        repeat (2) @(posedge ck);
    endtask : set_cfg

    function automatic logic pulse_of(input int sel, input int bank);
        case (sel)
            0:       return strobe_ref;
            1:       return rec_start;
            default: return int_pre[bank];
        endcase
    endfunction : pulse_of

    // Memory edges from a reference edge until the selected pulse
    task automatic wait_pulse(input int sel, input int bank, input logic [15:0] from,
                              input logic [7:0] exp);
        logic [7:0] got;
        got = 8'hff;
        for (int i = 0; i < 400; i++)
        begin
            @(negedge sys_clk);
            if (pulse_of(sel, bank) === 1'b1)
            begin
                got = 8'(ck_cnt - from);
                break;
            end
        end
        chk(got, exp);
    endtask : wait_pulse

    task automatic t_wr_value();
        set_cfg(5'h05, 5'h00, 5'h05, 2'h0, 1'b1, 8'h06);
        chk(wr_ck, 8'h08);
        set_cfg(5'h05, 5'h00, 5'h05, 2'h0, 1'b0, 8'h06);
        chk(wr_ck, 8'h06);
    endtask : t_wr_value

    task automatic one_read(input logic [4:0] rl, input logic [4:0] al, input logic [7:0] exp);
        logic [15:0] t0;
        set_cfg(rl, al, 5'h05, 2'h0, 1'b1, 8'h06);
        model_u.send_cmd(4'h5, 3'h0, 1'b0);
        t0 = ck_cnt;
        wait_pulse(0, 0, t0, exp);
    endtask : one_read

    task automatic t_read_ref();
        one_read(5'h05, 5'h00, 8'h04);
        one_read(5'h06, 5'h05, 8'h0a);
        one_read(5'h01, 5'h00, 8'h01);
    endtask : t_read_ref

    task automatic t_write_start();
        logic [15:0] t0;
        for (int b = 0; b < 3; b++)
        begin
            set_cfg(5'h05, 5'h00, 5'h05, 2'(b), 1'b0, 8'h06);
            model_u.send_cmd(4'h4, 3'h1, 1'b0);
            t0 = ck_cnt;
            wait_pulse(1, 0, t0, (b == 1) ? 8'h07 : 8'h09);
        end
    endtask : t_write_start

    task automatic t_auto_pre();
        logic [15:0] t0;
        set_cfg(5'h05, 5'h00, 5'h05, 2'h0, 1'b1, 8'h06);
        model_u.send_cmd(4'h3, 3'h3, 1'b0);
        t0 = ck_cnt;
        repeat (2) @(negedge sys_clk);
        chk({7'h00, bank_open[3]}, 8'h01);
        model_u.send_cmd(4'h5, 3'h3, 1'b1);
        wait_pulse(2, 3, t0, 8'h0a);
        repeat (2) @(negedge sys_clk);
        chk({7'h00, bank_open[3]}, 8'h00);
        model_u.send_cmd(4'h3, 3'h5, 1'b0);
        t0 = ck_cnt;
        model_u.send_cmd(4'h4, 3'h5, 1'b1);
        wait_pulse(2, 5, t0, 8'h13);
    endtask : t_auto_pre

    initial
    begin
        resetn          = 1'b0;
        cfg             = '0;
        ck_cnt          = '0;
        cyc             = 0;
        fails           = 0;
        samples_checked = 0;
        repeat (6) @(posedge sys_clk);
        #2 resetn = 1'b1;
        repeat (4) @(posedge ck);
        t_wr_value();
        t_read_ref();
        t_write_start();
        t_auto_pre();
        chk({7'h00, ck_cnt > REF_POSTPONE_CK}, 8'h00);
        end_sim();
    end
endmodule : sdct_top_tb
